/* core/drc_map.vh */
/*
 constants for the dual reload counters and shared prescaler block:
 register indices, field positions, reset values and clock rates.
 assumes inclusion by bare name from the core modules.
*/
`ifndef DRC_MAP_VH
`define DRC_MAP_VH

// register indices on the control port
`define DRC_IDX_COUNTER_ONE_OVERFLOW 3'h0
`define DRC_IDX_COUNTER_TWO_OVERFLOW 3'h1
`define DRC_IDX_CLKSEL 3'h2
`define DRC_IDX_IMASK 3'h3
`define DRC_IDX_FLAGS 3'h4
`define DRC_IDX_CTRL 3'h5
`define DRC_IDX_TIMER 3'h6

// counter clock select fields
`define DRC_C1_DIV_LSB 0
`define DRC_C1_SRC_BIT 3
`define DRC_C2_DIV_LSB 4
`define DRC_C2_SRC_BIT 7

// control register fields
`define DRC_CTL_RATIO_LSB 0
`define DRC_CTL_ASSIGN_BIT 3
`define DRC_CTL_SRC_BIT 5

// flag bit positions
`define DRC_FLG_TIMER 0
`define DRC_FLG_COUNTER_ONE_OVERFLOW 4
`define DRC_FLG_COUNTER_TWO_OVERFLOW 5
`define DRC_MASK_RSVD 8'hbf

// reset values
`define DRC_RST_CNT 8'h00
`define DRC_RST_CLKSEL 8'h00
`define DRC_RST_IMASK 8'h00
`define DRC_RST_FLAGS 8'h00
`define DRC_RST_CTRL 8'hef

// clock rates in hz
`define DRC_MCLK_HZ 20000000
`define DRC_LF_HZ 32768
`define DRC_SLOW_HZ 16384

`endif

/* core/drc_divider.v */
/*
 power-of-two prescaler driven by a one-cycle source enable; emits one
 pulse per 2**code source pulses. assumes a single clock and a clear
 from the parent when the divide chain must restart.
*/
`timescale 1ns/1ps
module drc_divider #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_b,
  input wire clr,
  input wire src_en,
  input wire [3:0] code,
  output wire tick,
  output wire [WIDTH-1:0] count
);
  reg [WIDTH-1:0] cnt_reg;
  reg [WIDTH-1:0] cnt_next;
  wire [WIDTH:0] terminal;

  assign terminal = ({{WIDTH{1'b0}}, 1'b1} << code) - {{WIDTH{1'b0}}, 1'b1};
  // new code is judged against the running count, so it bites in the current period
  assign tick = src_en && ({1'b0, cnt_reg} >= terminal);
  assign count = cnt_reg;

  always @* begin
    cnt_next = cnt_reg;
    if (clr)
      cnt_next = {WIDTH{1'b0}};
    else if (tick)
      cnt_next = {WIDTH{1'b0}};
    else if (src_en)
      cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  always @(posedge mclk) begin
    if (!rst_b)
      cnt_reg <= {WIDTH{1'b0}};
    else
      cnt_reg <= cnt_next;
  end
endmodule

/* core/drc_reload_counter.v */
/*
 8-bit reloadable up-counter with preset buffer. counts on adv, reloads
 the preset on wrap and flags the overflow for one cycle.
 assumes the parent gives a one-cycle write strobe.
*/
`timescale 1ns/1ps
module drc_reload_counter #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_b,
  input wire wr,
  input wire [WIDTH-1:0] wdata,
  input wire adv,
  output wire [WIDTH-1:0] count,
  output wire ovf
);
  reg [WIDTH-1:0] cnt_reg;
  reg [WIDTH-1:0] preset_reg;

  assign count = cnt_reg;
  assign ovf = adv && !wr && (&cnt_reg);

  always @(posedge mclk) begin
    if (!rst_b) begin
      cnt_reg <= {WIDTH{1'b0}};
      preset_reg <= {WIDTH{1'b0}};
    end else if (wr) begin
      cnt_reg <= wdata;
      preset_reg <= wdata;
    end else if (ovf) begin
      cnt_reg <= preset_reg;
    end else if (adv) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* core/drc_timer_core.v */
/*
 counting block of a small controller: two reload counters with their
 own dividers, the shared main timer / watchdog prescaler, the main
 timer, flag and mask registers. assumes the cpu side presents one-cycle
 read and write strobes with a 3-bit index and decoded clear-watchdog
 and sleep instruction strobes.
*/
// Behaviour
// - each counter is 8-bit up; write presets count, read returns count
// - on overflow a counter reloads the last written preset and continues
// - clock select bits 0-2 set counter one divide 1 to 128, reset 000
// - clock select bit 3: counter one source, 0 32.768 khz clock, 1 instruction
// - clock select bits 4-6 set counter two divide 1 to 128, reset 000
// - clock select bit 7: counter two source, 0 32.768 khz clock, 1 instruction
// - instruction clock period is twice the main clock period
// - mask bits 0-5 and 7 enable their sources; 1 enables
// - mask bit 6 is read-only zero
// - mask register is read/write and gates the matching flags
// - one 8-bit prescaler serves main timer or watchdog, never both
// - control bit 3 chooses which one owns the prescaler
// - writing the main timer clears the timer and the shared prescaler
// - with watchdog owning it, clear or sleep instruction clears prescaler
// - with main timer owning it, sleep leaves the prescaler alone
// - assign 0 main timer 1:2..1:256, 1 watchdog 1:1..1:128
// - counter one overflow sets flag 4, counter two flag 5; sw clears
// - main timer source bit: 0 instruction clock, 1 16.38 khz clock
`timescale 1ns/1ps
`include "drc_map.vh"
module drc_timer_core #(
  parameter CNT_W = 8,
  parameter LF_DIV = 610,
  parameter SLOW_DIV = 1221
) (
  input wire mclk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [2:0] reg_idx,
  input wire [7:0] reg_wdata,
  input wire watchdog_clear_instruction,
  input wire sleep_instruction,
  input wire pin_interrupt_zero,
  input wire pin_interrupt_one,
  input wire pin_interrupt_two_three,
  input wire energy_detector_event,
  output reg [7:0] reg_rdata,
  output reg [7:0] pending_irq,
  output reg watchdog_tick,
  output reg main_timer_overflow,
  output reg counter_one_overflow,
  output reg counter_two_overflow
);
  // full-width terms first, then cut to the 16-bit rate counters on purpose
  localparam [31:0] LF_TERM_W = LF_DIV - 1;
  localparam [31:0] SLOW_TERM_W = SLOW_DIV - 1;
  localparam [15:0] LF_TERM = LF_TERM_W[15:0];
  localparam [15:0] SLOW_TERM = SLOW_TERM_W[15:0];

  reg [7:0] counter_clock_select_reg;
  reg [7:0] interrupt_enable_mask_reg;
  reg [7:0] interrupt_flag_register_reg;
  reg [7:0] interrupt_flag_register_next;
  reg [7:0] control_register_reg;
  reg [7:0] main_timer_reg;
  reg inst_phase_reg;
  reg [15:0] lf_cnt_reg;
  reg [15:0] slow_cnt_reg;
  reg [7:0] raw_evt;
  reg [7:0] rdata_next;

  wire inst_en;
  wire lf_en;
  wire slow_en;
  wire wr_counter_one_overflow;
  wire wr_counter_two_overflow;
  wire wr_timer;
  wire [7:0] counter_one_overflow_val;
  wire [7:0] counter_two_overflow_val;
  wire counter_one_overflow_adv;
  wire counter_two_overflow_adv;
  wire counter_one_overflow_ovf;
  wire counter_two_overflow_ovf;
  wire [7:0] counter_one_data;
  wire [7:0] counter_two_data;
  wire counter_one_source;
  wire counter_two_source;
  wire [2:0] counter_one_divider;
  wire [2:0] counter_two_divider;
  wire prescaler_assignment;
  wire main_timer_source;
  wire [2:0] shared_prescaler_ratio;
  wire [3:0] shared_code;
  wire main_src_en;
  wire shared_src_en;
  wire shared_clr;
  wire shared_tick;
  wire timer_step;
  wire timer_wrap;
  wire [7:0] interrupt_mask_alias;

  assign counter_one_divider = counter_clock_select_reg[`DRC_C1_DIV_LSB +: 3];
  assign counter_one_source = counter_clock_select_reg[`DRC_C1_SRC_BIT];
  assign counter_two_divider = counter_clock_select_reg[`DRC_C2_DIV_LSB +: 3];
  assign counter_two_source = counter_clock_select_reg[`DRC_C2_SRC_BIT];
  assign shared_prescaler_ratio = control_register_reg[`DRC_CTL_RATIO_LSB +: 3];
  assign prescaler_assignment = control_register_reg[`DRC_CTL_ASSIGN_BIT];
  assign main_timer_source = control_register_reg[`DRC_CTL_SRC_BIT];
  assign interrupt_mask_alias = interrupt_enable_mask_reg;

  // rate enables; instruction clock is every other main clock
  assign inst_en = inst_phase_reg;
  assign lf_en = (lf_cnt_reg == LF_TERM);
  assign slow_en = (slow_cnt_reg == SLOW_TERM);

  always @(posedge mclk) begin
    if (!rst_b) begin
      inst_phase_reg <= 1'b0;
      lf_cnt_reg <= 16'h0000;
      slow_cnt_reg <= 16'h0000;
    end else begin
      inst_phase_reg <= ~inst_phase_reg;
      lf_cnt_reg <= lf_en ? 16'h0000 : lf_cnt_reg + 16'h0001;
      slow_cnt_reg <= slow_en ? 16'h0000 : slow_cnt_reg + 16'h0001;
    end
  end

  assign wr_counter_one_overflow = reg_wr && (reg_idx == `DRC_IDX_COUNTER_ONE_OVERFLOW);
  assign wr_counter_two_overflow = reg_wr && (reg_idx == `DRC_IDX_COUNTER_TWO_OVERFLOW);
  assign wr_timer = reg_wr && (reg_idx == `DRC_IDX_TIMER);

  // divider structure keeps the preset path separate from source changes
  drc_divider #(.WIDTH(CNT_W)) u_div1 (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(1'b0),
    .src_en(counter_one_source ? inst_en : lf_en),
    .code({1'b0, counter_one_divider}),
    .tick(counter_one_overflow_adv),
    .count()
  );

  drc_divider #(.WIDTH(CNT_W)) u_div2 (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(1'b0),
    .src_en(counter_two_source ? inst_en : lf_en),
    .code({1'b0, counter_two_divider}),
    .tick(counter_two_overflow_adv),
    .count()
  );

  drc_reload_counter #(.WIDTH(CNT_W)) u_counter_one_overflow (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr(wr_counter_one_overflow),
    .wdata(reg_wdata),
    .adv(counter_one_overflow_adv),
    .count(counter_one_overflow_val),
    .ovf(counter_one_overflow_ovf)
  );

  drc_reload_counter #(.WIDTH(CNT_W)) u_counter_two_overflow (
    .mclk(mclk),
    .rst_b(rst_b),
    .wr(wr_counter_two_overflow),
    .wdata(reg_wdata),
    .adv(counter_two_overflow_adv),
    .count(counter_two_overflow_val),
    .ovf(counter_two_overflow_ovf)
  );

  assign counter_one_data = counter_one_overflow_val;
  assign counter_two_data = counter_two_overflow_val;

  // shared prescaler: owner picks source, code and clear terms
  assign main_src_en = main_timer_source ? slow_en : inst_en;
  assign shared_src_en = prescaler_assignment ? lf_en : main_src_en;
  // main timer uses ratio+1 (1:2..1:256), watchdog ratio (1:1..1:128)
  assign shared_code = prescaler_assignment ? {1'b0, shared_prescaler_ratio}
    : ({1'b0, shared_prescaler_ratio} + 4'h1);
  // sleep clears only while the watchdog owns it
  assign shared_clr = wr_timer ||
    (prescaler_assignment && (watchdog_clear_instruction || sleep_instruction));

  drc_divider #(.WIDTH(8)) u_shared (
    .mclk(mclk),
    .rst_b(rst_b),
    .clr(shared_clr),
    .src_en(shared_src_en),
    .code(shared_code),
    .tick(shared_tick),
    .count()
  );

  assign timer_step = shared_tick && !prescaler_assignment;
  assign timer_wrap = timer_step && !wr_timer && (&main_timer_reg);

  always @(posedge mclk) begin
    if (!rst_b)
      main_timer_reg <= `DRC_RST_CNT;
    else if (wr_timer)
      main_timer_reg <= `DRC_RST_CNT;
    else if (timer_step)
      main_timer_reg <= main_timer_reg + 8'h01;
  end

  // flag set wins over a simultaneous software clear
  always @* begin
    raw_evt = 8'h00;
    raw_evt[`DRC_FLG_TIMER] = timer_wrap;
    raw_evt[1] = pin_interrupt_zero;
    raw_evt[2] = pin_interrupt_one;
    raw_evt[3] = pin_interrupt_two_three;
    raw_evt[`DRC_FLG_COUNTER_ONE_OVERFLOW] = counter_one_overflow_ovf;
    raw_evt[`DRC_FLG_COUNTER_TWO_OVERFLOW] = counter_two_overflow_ovf;
    raw_evt[7] = energy_detector_event;
    interrupt_flag_register_next = interrupt_flag_register_reg;
    if (reg_wr && (reg_idx == `DRC_IDX_FLAGS))
      interrupt_flag_register_next = reg_wdata;
    // masked sources never latch
    interrupt_flag_register_next = (interrupt_flag_register_next |
      (raw_evt & interrupt_enable_mask_reg)) & `DRC_MASK_RSVD;
  end

  always @* begin
    case (reg_idx)
      `DRC_IDX_COUNTER_ONE_OVERFLOW: rdata_next = counter_one_data;
      `DRC_IDX_COUNTER_TWO_OVERFLOW: rdata_next = counter_two_data;
      `DRC_IDX_CLKSEL: rdata_next = counter_clock_select_reg;
      `DRC_IDX_IMASK: rdata_next = interrupt_mask_alias & `DRC_MASK_RSVD;
      `DRC_IDX_FLAGS: rdata_next = interrupt_flag_register_reg;
      `DRC_IDX_CTRL: rdata_next = control_register_reg;
      `DRC_IDX_TIMER: rdata_next = main_timer_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_b) begin
      counter_clock_select_reg <= `DRC_RST_CLKSEL;
      interrupt_enable_mask_reg <= `DRC_RST_IMASK;
      interrupt_flag_register_reg <= `DRC_RST_FLAGS;
      control_register_reg <= `DRC_RST_CTRL;
      reg_rdata <= 8'h00;
      pending_irq <= 8'h00;
      watchdog_tick <= 1'b0;
      main_timer_overflow <= 1'b0;
      counter_one_overflow <= 1'b0;
      counter_two_overflow <= 1'b0;
    end else begin
      if (reg_wr && (reg_idx == `DRC_IDX_CLKSEL))
        counter_clock_select_reg <= reg_wdata;
      if (reg_wr && (reg_idx == `DRC_IDX_IMASK))
        interrupt_enable_mask_reg <= reg_wdata & `DRC_MASK_RSVD;
      if (reg_wr && (reg_idx == `DRC_IDX_CTRL))
        control_register_reg <= reg_wdata & 8'hef;
      interrupt_flag_register_reg <= interrupt_flag_register_next;
      if (reg_rd)
        reg_rdata <= rdata_next;
      pending_irq <= interrupt_flag_register_next & interrupt_enable_mask_reg;
      watchdog_tick <= shared_tick && prescaler_assignment;
      main_timer_overflow <= timer_wrap;
      counter_one_overflow <= counter_one_overflow_ovf;
      counter_two_overflow <= counter_two_overflow_ovf;
    end
  end
endmodule

/* tb/drc_timer_core_assertions.sv */
/*
 checker for the counting block: read port, mask, pulses, timer clear.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module drc_timer_core_assertions (
  input wire mclk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [2:0] reg_idx,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [7:0] pending_irq,
  input wire main_timer_overflow,
  input wire counter_one_overflow,
  input wire counter_two_overflow
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_mask_rw;
    reg_wr && reg_idx == 3'h3 ##1 !reg_wr ##1 reg_rd && reg_idx == 3'h3
    |=> reg_rdata == ($past(reg_wdata, 3) & 8'hbf);
  endproperty
  a_mask_rw: assert property (p_mask_rw) else $error("mask readback");
  property p_mask_b6; reg_rd && reg_idx == 3'h3 |=> !reg_rdata[6]; endproperty
  a_mask_b6: assert property (p_mask_b6) else $error("mask bit 6 set");
  property p_pend_b6; !pending_irq[6]; endproperty
  a_pend_b6: assert property (p_pend_b6) else $error("pending bit 6 set");
  property p_ctl_b4; reg_rd && reg_idx == 3'h5 |=> !reg_rdata[4]; endproperty
  a_ctl_b4: assert property (p_ctl_b4) else $error("control bit 4 set");
  property p_unmap; reg_rd && reg_idx == 3'h7 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_c1_pulse; counter_one_overflow |=> !counter_one_overflow; endproperty
  a_c1_pulse: assert property (p_c1_pulse) else $error("counter one pulse long");
  property p_c2_pulse; counter_two_overflow |=> !counter_two_overflow; endproperty
  a_c2_pulse: assert property (p_c2_pulse) else $error("counter two pulse long");
  property p_tmr_clr; reg_wr && reg_idx == 3'h6 |=> ##1 !main_timer_overflow [*8]; endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer overflow after clear");
  property p_c1_wr; reg_wr && reg_idx == 3'h0 |=> !counter_one_overflow; endproperty
  a_c1_wr: assert property (p_c1_wr) else $error("overflow after preset");
endmodule
bind drc_timer_core drc_timer_core_assertions u_chk (.mclk(mclk), .rst_b(rst_b),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .pending_irq(pending_irq),
  .main_timer_overflow(main_timer_overflow), .counter_one_overflow(counter_one_overflow),
  .counter_two_overflow(counter_two_overflow));

/* tb/drc_timer_core_bench.sv */
/*
 self-checking bench for the counting block: periods against a model.
 assumes short slow-clock dividers; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module drc_timer_core_bench;
  localparam int LFD = 4;
  localparam int SDV = 4;
  reg mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, wdc = 0, slp = 0, ev = 0;
  reg [2:0] reg_idx = 0;
  reg [7:0] reg_wdata = 0, d;
  reg [31:0] rs = 80602;
  wire [7:0] reg_rdata, pending_irq;
  wire wd_tick, t_ovf, c1_ovf, c2_ovf;
  int n_errors = 0, n_checks = 0, cyc = 0, t0, i, c, n, p, s;
  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  drc_timer_core #(.LF_DIV(LFD), .SLOW_DIV(SDV)) u_dut (.mclk(mclk), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .watchdog_clear_instruction(wdc), .sleep_instruction(slp), .pin_interrupt_zero(ev),
    .pin_interrupt_one(ev), .pin_interrupt_two_three(ev), .energy_detector_event(ev),
    .reg_rdata(reg_rdata), .pending_irq(pending_irq), .watchdog_tick(wd_tick),
    .main_timer_overflow(t_ovf), .counter_one_overflow(c1_ovf),
    .counter_two_overflow(c2_ovf));
  function logic [31:0] nxt;
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] sn, input logic [15:0] ex);
    n_checks++;
    if (sn !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  // both tasks start and end at a falling edge; the lead-in cycle keeps a
  // strobe from being dropped and raised again in one time step
  task wr(input [2:0] x, input [7:0] v);
    @(negedge mclk);
    reg_idx = x;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge mclk) reg_wr = 0;
  endtask
  task rd(input [2:0] x);
    @(negedge mclk);
    reg_idx = x;
    reg_rd = 1;
    @(negedge mclk) reg_rd = 0;
    d = reg_rdata;
  endtask
  function logic pk(input int w);
    case (w)
      0: return c1_ovf === 1'b1;
      1: return c2_ovf === 1'b1;
      2: return t_ovf === 1'b1;
      default: return wd_tick === 1'b1;
    endcase
  endfunction
  task wp(input int w);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1 k++;
    end while (!pk(w) && k < 30000);
    if (k >= 30000) begin
      n_errors++;
      final_report;
    end else begin
      @(negedge mclk);
    end
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1;
    for (i = 2; i < 8; i++) if (i != 6) begin
      rd(i[2:0]);
      chk("reset value", d, (i == 5) ? 8'hef : 8'h00);
    end
    $display("test reset done");
    p = nxt();
    wr(3, p[7:0]);
    rd(3);
    chk("mask", d, p[7:0] & 8'hbf);
    wr(3, 8'hff);
    ev = 1;
    @(negedge mclk) ev = 0;
    rd(4);
    chk("pin flags", d & 8'h8e, 8'h8e);
    chk("pending", pending_irq & 8'h8e, 8'h8e);
    wr(4, 8'h00);
    rd(4);
    chk("flags cleared", d & 8'h8e, 8'h00);
    $display("test mask done");
    for (n = 0; n < 2; n++) for (c = 0; c < 8; c++) begin
      p = 8'hfc | (nxt() & 3);
      s = c[0] ^ n;
      wr(2, n ? {s[0], c[2:0], 4'h0} : {4'h0, s[0], c[2:0]});
      wr(n[2:0], p[7:0]);
      rd(n[2:0]);
      // at most one step, or a reload to the same preset, since the write
      chk("count read", 16'(8'(d - p[7:0]) < 8'd2), 16'd1);
      wp(n);
      t0 = cyc;
      wp(n);
      chk("period", 16'(cyc - t0), 16'(((256 - p) << c) * (s ? 2 : LFD)));
      rd(4);
      chk("counter flag", d[4+n], 1'b1);
      wr(4, 8'h00);
    end
    $display("test counters done");
    wr(5, 8'h00);
    wp(2);
    t0 = cyc;
    repeat (300) @(negedge mclk);
    slp = 1;
    @(negedge mclk) slp = 0;
    wp(2);
    chk("timer period", 16'(cyc - t0), 16'd1024);
    repeat (500) @(negedge mclk);
    wr(6, 8'(nxt()));
    t0 = cyc;
    wp(2);
    chk("timer clear", 16'((cyc - t0 > 1020) && (cyc - t0 < 1028)), 16'd1);
    wr(5, 8'h20);
    wp(2);
    t0 = cyc;
    wp(2);
    chk("slow timer", 16'(cyc - t0), 16'(512 * SDV));
    wr(5, 8'h0a);
    wp(3);
    t0 = cyc;
    wp(3);
    chk("watchdog period", 16'(cyc - t0), 16'(LFD << 2));
    for (i = 0; i < 2; i++) begin
      wp(3);
      t0 = cyc;
      repeat (6) @(negedge mclk);
      wdc = (i == 0);
      slp = (i == 1);
      @(negedge mclk) wdc = 0;
      slp = 0;
      wp(3);
      chk("watchdog clear", 16'(cyc - t0 > (LFD << 2)), 16'd1);
    end
    $display("test prescaler done");
    final_report;
  end
endmodule
